// File: common/dosst_pkg.sv
// Summary of operation
// - Sample four active-low ID inputs over a 250 ms window after reset; low means one.
// - Neither spin strap active: start the spindle as soon as power-up completes.
// - Only start-by-command active: hold spindle stopped until a Start Unit command.
// - Only delayed-spin active: wait ID times 12 seconds, ID zero starts at once.
// - Both spin straps active: command start wins, the ID delay is ignored.
// - Parity-off strap active: no parity checking and no parity error reports.
// - Parity-off strap inactive: check received parity and report the outcome.
// - Force-single-ended strap active: use single-ended drivers and receivers always.
// - Force strap inactive: bus mode follows the differential-sense line.
// - Straps take effect only as captured at power-up; changes need a power cycle.
package dosst_pkg;
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned ID_WINDOW_MS = 250;
    localparam int unsigned SPIN_STEP_S = 12;
    localparam int unsigned MS_TICKS = CLK_HZ / 1000;
    localparam int unsigned ID_WIDTH = 4;
    localparam logic [3:0] ID_RESET = 4'h0;

    typedef enum logic [4:0] {
        DOSST_SAMPLE = 5'h01,
        DOSST_DECIDE = 5'h02,
        DOSST_DELAY = 5'h04,
        DOSST_WAIT_CMD = 5'h08,
        DOSST_RUN = 5'h10
    } dosst_state_e;
endpackage

// File: common/dosst_tick_if.sv
`timescale 1ns/1ps
interface dosst_tick_if;
    logic clear;
    logic tick;
    modport master (output clear, input tick);
    modport divider (input clear, output tick);
endinterface

// File: src/dosst_divider.sv
`timescale 1ns/1ps
module dosst_divider #(
    parameter int unsigned DIV = 125000
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    dosst_tick_if.divider tk
);
    localparam int unsigned CW = $clog2(DIV + 1);
    if (DIV < 2) begin : g_bad_div
        $error("divider ratio too small");
    end
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic tick_q;
    logic tick_d;

    always_comb begin
        tick_d = 1'b0;
        cnt_d = cnt_q + 1'b1;
        if (tk.clear) begin
            cnt_d = '0;
        end else if (cnt_q == CW'(DIV - 1)) begin
            cnt_d = '0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end
    assign tk.tick = tick_q;
endmodule // dosst_divider

// File: src/dosst_startup.sv
`timescale 1ns/1ps
module dosst_startup #(
    parameter int unsigned MS_DIV = dosst_pkg::MS_TICKS,
    parameter int unsigned WINDOW_MS = dosst_pkg::ID_WINDOW_MS,
    parameter int unsigned STEP_MS = dosst_pkg::SPIN_STEP_S * 1000
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [dosst_pkg::ID_WIDTH-1:0] drive_id_n_in,
    input wire logic delayed_spin_strap_in,
    input wire logic start_by_command_strap_in,
    input wire logic parity_check_off_strap_in,
    input wire logic force_single_ended_strap_in,
    input wire logic diffsens_lvd_in,
    input wire logic start_unit_cmd_in,
    output logic [dosst_pkg::ID_WIDTH-1:0] bus_id_out,
    output logic id_valid_out,
    output logic spindle_start_out,
    output logic parity_check_en_out,
    output logic single_ended_out
);
    import dosst_pkg::*;

    // ********************************
    // Parameter checks
    // ********************************
    // Width of the millisecond counter; longer windows or steps need a wider one
    localparam int MW = 24;
    if (WINDOW_MS < 1 || WINDOW_MS >= (1 << MW)) begin : g_bad_window
        $error("window length out of range");
    end
    if (STEP_MS < 1 || STEP_MS >= (1 << MW)) begin : g_bad_step
        $error("step length out of range");
    end
    if (MS_DIV < 2) begin : g_bad_div
        $error("tick divider too small");
    end
    if (ID_WIDTH != 4) begin : g_bad_id
        $error("sequencer is built for a four-bit id");
    end

    // ********************************
    // Input synchronisers
    // ********************************
    // Straps are active-high here: the pad logic presents an installed jumper as 1
    // Reset values are the idle pin levels, so no false command or strap follows reset
    logic [9:0] s1_q;
    logic [9:0] s2_q;
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s1_q <= 10'h20F;
            s2_q <= 10'h20F;
        end else begin
            s1_q <= {diffsens_lvd_in, start_unit_cmd_in, force_single_ended_strap_in, parity_check_off_strap_in,
                     start_by_command_strap_in, delayed_spin_strap_in, drive_id_n_in};
            s2_q <= s1_q;
        end
    end
    logic [3:0] id_n_s;
    logic dly_spin_s;
    logic cmd_mode_s;
    logic par_off_s;
    logic force_sgl_s;
    logic cmd_s;
    logic lvd_s;
    assign id_n_s = s2_q[3:0];
    assign dly_spin_s = s2_q[4];
    assign cmd_mode_s = s2_q[5];
    assign par_off_s = s2_q[6];
    assign force_sgl_s = s2_q[7];
    assign cmd_s = s2_q[8];
    assign lvd_s = s2_q[9];

    // ********************************
    // Millisecond tick
    // ********************************
    dosst_tick_if tk ();
    dosst_divider #(.DIV(MS_DIV)) u_div (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .tk(tk)
    );

    // ********************************
    // Startup sequencer
    // ********************************
    dosst_state_e st_q, st_d;
    logic [MW-1:0] ms_q, ms_d;
    logic [3:0] step_q, step_d;
    logic [3:0] id_q, id_d;
    logic dly_spin_q;
    logic dly_spin_d;
    logic cmd_mode_q;
    logic cmd_mode_d;
    logic par_off_q;
    logic par_off_d;
    logic force_sgl_q;
    logic force_sgl_d;
    logic idv_q, idv_d, spin_q, spin_d;

    always_comb begin
        st_d = st_q;
        ms_d = ms_q;
        step_d = step_q;
        id_d = id_q;
        dly_spin_d = dly_spin_q;
        cmd_mode_d = cmd_mode_q;
        par_off_d = par_off_q;
        force_sgl_d = force_sgl_q;
        idv_d = idv_q;
        spin_d = spin_q;
        tk.clear = 1'b0;
        case (st_q)
            DOSST_SAMPLE: begin
                // Keep following the pins for the whole window; the last value stands
                id_d = ~id_n_s;
                dly_spin_d = dly_spin_s;
                cmd_mode_d = cmd_mode_s;
                par_off_d = par_off_s;
                force_sgl_d = force_sgl_s;
                if (tk.tick) begin
                    ms_d = ms_q + 1'b1;
                    if (ms_q == MW'(WINDOW_MS - 1)) begin
                        st_d = DOSST_DECIDE;
                        idv_d = 1'b1;
                    end
                end
            end
            DOSST_DECIDE: begin
                // Command start is tested first so that it overrides the ID delay
                if (cmd_mode_q) begin
                    st_d = DOSST_WAIT_CMD;
                end else if (dly_spin_q && id_q != 4'h0) begin
                    st_d = DOSST_DELAY;
                    ms_d = '0;
                    step_d = id_q;
                    tk.clear = 1'b1;
                end else begin
                    st_d = DOSST_RUN;
                    spin_d = 1'b1;
                end
            end
            DOSST_DELAY: begin
                // Delay counts from window end; the 250 ms window is small beside a 12 s step
                if (tk.tick) begin
                    if (ms_q == MW'(STEP_MS - 1)) begin
                        ms_d = '0;
                        step_d = step_q - 1'b1;
                        if (step_q == 4'h1) begin
                            st_d = DOSST_RUN;
                            spin_d = 1'b1;
                        end
                    end else begin
                        ms_d = ms_q + 1'b1;
                    end
                end
            end
            DOSST_WAIT_CMD: begin
                // Start Unit is honoured only here; every other state ignores it
                if (cmd_s) begin
                    st_d = DOSST_RUN;
                    spin_d = 1'b1;
                end
            end
            DOSST_RUN: begin
                spin_d = 1'b1;
            end
            default: begin
                st_d = DOSST_SAMPLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_q <= DOSST_SAMPLE;
            ms_q <= '0;
            step_q <= 4'h0;
            id_q <= ID_RESET;
            dly_spin_q <= 1'b0;
            cmd_mode_q <= 1'b0;
            par_off_q <= 1'b0;
            force_sgl_q <= 1'b0;
            idv_q <= 1'b0;
            spin_q <= 1'b0;
        end else begin
            st_q <= st_d;
            ms_q <= ms_d;
            step_q <= step_d;
            id_q <= id_d;
            dly_spin_q <= dly_spin_d;
            cmd_mode_q <= cmd_mode_d;
            par_off_q <= par_off_d;
            force_sgl_q <= force_sgl_d;
            idv_q <= idv_d;
            spin_q <= spin_d;
        end
    end

    // ********************************
    // Bus mode and parity outputs
    // ********************************
    logic par_q;
    logic par_d;
    logic sem_q;
    logic sem_d;
    always_comb begin
        par_d = ~par_off_q;
        sem_d = force_sgl_q | ~lvd_s;
    end
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            par_q <= 1'b1;
            sem_q <= 1'b1;
        end else begin
            par_q <= par_d;
            sem_q <= sem_d;
        end
    end

    assign bus_id_out = id_q;
    assign id_valid_out = idv_q;
    assign spindle_start_out = spin_q;
    assign parity_check_en_out = par_q;
    assign single_ended_out = sem_q;
endmodule // dosst_startup

// File: testbench/dosst_startup_chk.sv
`timescale 1ns/1ps
module dosst_startup_chk #(
    parameter int unsigned MS_DIV = 4,
    parameter int unsigned WINDOW_MS = 3,
    parameter int unsigned STEP_MS = 5
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [dosst_pkg::ID_WIDTH-1:0] drive_id_n_in,
    input wire logic delayed_spin_strap_in,
    input wire logic start_by_command_strap_in,
    input wire logic parity_check_off_strap_in,
    input wire logic force_single_ended_strap_in,
    input wire logic diffsens_lvd_in,
    input wire logic start_unit_cmd_in,
    input wire logic [dosst_pkg::ID_WIDTH-1:0] bus_id_out,
    input wire logic id_valid_out,
    input wire logic spindle_start_out,
    input wire logic parity_check_en_out,
    input wire logic single_ended_out
);
    import dosst_pkg::*;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    // ************
    // Properties
    // ************
    AST_ID_FROZEN: assert property (id_valid_out && $past(id_valid_out) |-> $stable(bus_id_out))
        else $error("bus id moved");
    AST_VALID_STICKY: assert property (id_valid_out |=> id_valid_out)
        else $error("id valid dropped");
    AST_SPIN_STICKY: assert property (spindle_start_out |=> spindle_start_out)
        else $error("spindle dropped");
    AST_NO_EARLY_SPIN: assert property (!id_valid_out |-> !spindle_start_out)
        else $error("spindle in window");
    AST_PARITY_HELD: assert property (id_valid_out && $past(id_valid_out) |-> $stable(parity_check_en_out))
        else $error("parity mode moved");
    AST_SINGLE_FOLLOW: assert property (!diffsens_lvd_in [*4] |-> single_ended_out)
        else $error("no single ended");
    AST_IMMED: assert property ($rose(id_valid_out) && !delayed_spin_strap_in && !start_by_command_strap_in
        |-> ##[1:3] spindle_start_out)
        else $error("late immediate start");
    AST_CMD_START: assert property (start_by_command_strap_in && id_valid_out && $rose(start_unit_cmd_in)
        |-> ##[1:6] spindle_start_out)
        else $error("command start late");
    AST_CMD_CAUSE: assert property ($rose(spindle_start_out) && start_by_command_strap_in
        |-> $past(start_unit_cmd_in, 2) || $past(start_unit_cmd_in, 3) || $past(start_unit_cmd_in, 4))
        else $error("start without command");
endmodule // dosst_startup_chk

// File: testbench/dosst_host_model.sv
`timescale 1ns/1ps
module dosst_host_model (
    input wire logic sys_clk_in,
    input wire logic [7:0] cfg_in,
    input wire logic cmd_req_in,
    output logic [3:0] drive_id_n_out,
    output logic [3:0] straps_out,
    output logic cmd_out
);
    // Host holds levels steady; the command lasts one clock
    always_ff @(posedge sys_clk_in) begin
        drive_id_n_out <= cfg_in[3:0];
        straps_out <= cfg_in[7:4];
        cmd_out <= cmd_req_in;
    end
endmodule // dosst_host_model

// File: testbench/test_drive_option_strap_startup.sv
`timescale 1ns/1ps
module test_drive_option_strap_startup;
    import dosst_pkg::*;
    // Short counts: ms tick 4 clocks, window 3 ticks, step 5 ticks
    localparam int T_DIV = 4;
    localparam int T_WIN = 3;
    localparam int T_STEP = 5;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] cfg = 8'h0F;
    logic cmd_req = 1'b0;
    logic diffsens = 1'b1;
    logic [3:0] id_n, straps, bus_id;
    logic cmd, id_valid, spin, par_en, se_mode;
    int n_errors = 0;
    int samples_checked = 0;
    initial begin
        forever #4 clk = ~clk;
    end
    dosst_host_model i_host (.sys_clk_in(clk), .cfg_in(cfg), .cmd_req_in(cmd_req),
        .drive_id_n_out(id_n), .straps_out(straps), .cmd_out(cmd));
    dosst_startup #(.MS_DIV(T_DIV), .WINDOW_MS(T_WIN), .STEP_MS(T_STEP)) i_dut (.sys_clk_in(clk), .reset_n_in(reset_n),
        .drive_id_n_in(id_n), .delayed_spin_strap_in(straps[0]), .start_by_command_strap_in(straps[1]),
        .parity_check_off_strap_in(straps[2]), .force_single_ended_strap_in(straps[3]),
        .diffsens_lvd_in(diffsens), .start_unit_cmd_in(cmd), .bus_id_out(bus_id), .id_valid_out(id_valid),
        .spindle_start_out(spin), .parity_check_en_out(par_en), .single_ended_out(se_mode));
    // ************
    // Tasks
    // ************
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_cycles(input int got, input int lo, input int hi);
        samples_checked++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("ERROR %0t took %0d cycles, want %0d to %0d", $time, got, lo, hi);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic hang();
        $display("ERROR %0t wait hang", $time);
        n_errors++;
        report_and_stop();
    endtask
    task automatic boot(input logic [7:0] c);
        int k;
        cfg <= c;
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk({id_valid, spin, par_en, se_mode}, 4'h3);
        reset_n <= 1'b1;
        k = 0;
        while (id_valid !== 1'b1 && k < 200) begin
            @(posedge clk);
            k++;
        end
        if (k == 200) hang();
        chk_cycles(k, T_WIN * T_DIV, T_WIN * T_DIV + 3);
        chk(bus_id, ~c[3:0]);
    endtask
    task automatic spin_wait(output int n);
        n = 0;
        while (spin !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (n == 400) hang();
    endtask
    task automatic t_immediate();
        int n;
        boot(8'h05);
        spin_wait(n);
        chk_cycles(n, 1, 4);
        chk({2'h0, par_en, se_mode}, 4'h2);
        diffsens <= 1'b0;
        repeat (4) @(posedge clk);
        chk({3'h0, se_mode}, 4'h1);
        diffsens <= 1'b1;
        $display("immediate done");
    endtask
    task automatic t_delay();
        int n;
        boot(8'h1D);
        spin_wait(n);
        chk_cycles(n, 2 * T_STEP * T_DIV, 2 * T_STEP * T_DIV + T_DIV + 2);
        boot(8'h1F);
        spin_wait(n);
        chk_cycles(n, 1, 4);
        $display("delay done");
    endtask
    task automatic t_command(input logic [7:0] c);
        int n;
        boot(c);
        repeat (60) @(posedge clk);
        chk({3'h0, spin}, 4'h0);
        cmd_req <= 1'b1;
        @(posedge clk);
        cmd_req <= 1'b0;
        spin_wait(n);
        chk_cycles(n, 3, 6);
        $display("command done");
    endtask
    task automatic t_capture();
        boot(8'hCF);
        repeat (4) @(posedge clk);
        chk({2'h0, par_en, se_mode}, 4'h1);
        cfg <= 8'h05;
        repeat (10) @(posedge clk);
        chk({2'h0, par_en, se_mode}, 4'h1);
        chk(bus_id, 4'h0);
        $display("capture done");
    endtask
    initial begin
        t_immediate();
        t_delay();
        t_command(8'h2F);
        t_command(8'h3E);
        t_capture();
        report_and_stop();
    end
endmodule // test_drive_option_strap_startup
bind dosst_startup dosst_startup_chk #(.MS_DIV(MS_DIV), .WINDOW_MS(WINDOW_MS), .STEP_MS(STEP_MS)) i_chk (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .drive_id_n_in(drive_id_n_in),
    .delayed_spin_strap_in(delayed_spin_strap_in), .start_by_command_strap_in(start_by_command_strap_in),
    .parity_check_off_strap_in(parity_check_off_strap_in), .force_single_ended_strap_in(force_single_ended_strap_in),
    .diffsens_lvd_in(diffsens_lvd_in), .start_unit_cmd_in(start_unit_cmd_in), .bus_id_out(bus_id_out),
    .id_valid_out(id_valid_out), .spindle_start_out(spindle_start_out),
    .parity_check_en_out(parity_check_en_out), .single_ended_out(single_ended_out));
